/* pdm_defs.vh */
// Constants shared by the descriptor DMA controller files
// Operation
// - Controller drives table entries to movers on two 160-bit buses.
// - Write mover moves data only from local side toward host.
// - Read mover issues memory reads; completions go to local master port.
// - Read requests obey tags, credits, completion boundary, size, no 4 KB crossing.
// - Write mover fetches local data via own master, sends memory writes.
// - Write packets respect credits, payload size, never cross 4 KB.
// - Controller has read mover copy the table, up to FIFO depth entries, into local FIFO.
// - Entries popped one at a time, each to its proper mover.
// - Status for each descriptor written upstream via single-dword TX port.
// - MSI requests issued through the same single-dword TX port.
// - Host BAR0-1 accesses reach the controller's internal registers.
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH

// ----------------------------------------------------------------
// Host register offsets (dword index on the host register master)
// ----------------------------------------------------------------
`define PDM_REG_TBL_LO 4'h0
`define PDM_REG_TBL_HI 4'h1
`define PDM_REG_TBL_CNT 4'h2
`define PDM_REG_STS_LO 4'h3
`define PDM_REG_STS_HI 4'h4
`define PDM_REG_MSI_LO 4'h5
`define PDM_REG_MSI_HI 4'h6
`define PDM_REG_MSI_DATA 4'h7
`define PDM_REG_CTRL 4'h8
`define PDM_CTRL_MSI_EN 0

// ----------------------------------------------------------------
// Descriptor entry layout (160 bits)
// ----------------------------------------------------------------
`define PDM_ENTRY_W 160
`define PDM_ENTRY_BYTES 32'h0000_0014
`define PDM_F_ID_LSB 146
`define PDM_F_ID_MSB 153
`define PDM_F_DIR 159

// ----------------------------------------------------------------
// Status word, boundaries, reset values
// ----------------------------------------------------------------
`define PDM_STS_DONE 31
`define PDM_PAGE_BYTES 13'h1000
`define PDM_ONE 1'b1
`define PDM_ZERO 1'b0

`endif

/* pdm_split.v */
// Request length splitter: limits a chunk by size and 4 KB page boundary
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defs.vh"
module pdm_split #(
    parameter MAX_BYTES = 512
) (
    input wire [11:0] page_offs,
    input wire [31:0] remain,
    output reg [12:0] chunk
);
    reg [12:0] to_page;
    reg [12:0] max_b;

    always @* begin
        to_page = `PDM_PAGE_BYTES - {1'b0, page_offs};
        max_b = MAX_BYTES[12:0];
        chunk = max_b;
        if (to_page < chunk) begin
            chunk = to_page;
        end
        if (remain < {19'h00000, chunk}) begin
            chunk = remain[12:0];
        end
    end
endmodule // pdm_split
`default_nettype wire

/* pdm_skid.v */
// Two-entry skid buffer with registered outputs
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defs.vh"
module pdm_skid #(
    parameter W = 96
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output reg in_ready,
    output reg out_valid,
    output reg [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] skid_q;
    reg skid_valid_q;
    wire accept;

    assign accept = in_valid & in_ready;

    // A second slot lets the source see ready from a flop without losing
    // the word taken in the cycle the sink stalls.
    always @(posedge clk) begin
        if (srst) begin
            in_ready <= `PDM_ZERO;
            out_valid <= `PDM_ZERO;
            out_data <= {W{`PDM_ZERO}};
            skid_q <= {W{`PDM_ZERO}};
            skid_valid_q <= `PDM_ZERO;
        end else if (ce) begin
            if (!out_valid || out_ready) begin
                if (skid_valid_q) begin
                    out_valid <= `PDM_ONE;
                    out_data <= skid_q;
                    skid_valid_q <= `PDM_ZERO;
                    in_ready <= `PDM_ONE;
                end else begin
                    out_valid <= accept;
                    out_data <= in_data;
                    in_ready <= `PDM_ONE;
                end
            end else if (accept) begin
                skid_q <= in_data;
                skid_valid_q <= `PDM_ONE;
                in_ready <= `PDM_ZERO;
            end
        end
    end
endmodule // pdm_skid
`default_nettype wire

/* pdm_desc_ctrl.v */
// Descriptor controller: table fetch, dispatch to movers, status and MSI
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defs.vh"
module pdm_desc_ctrl #(
    parameter FIFO_AW = 4,
    parameter MAX_RD_BYTES = 512
) (
    input wire clk,
    input wire srst,
    input wire ce,
    // Host register master (write side of the BAR0-1 window)
    input wire host_register_master_write,
    input wire [3:0] host_register_master_addr,
    input wire [31:0] host_register_master_wdata,
    // Table fetch requests to the read mover
    output reg rdreq_valid,
    output reg [63:0] rdreq_addr,
    output reg [12:0] rdreq_bytes,
    input wire rdreq_ready,
    // Table entries returned by the read mover
    input wire tbl_valid,
    input wire [159:0] tbl_data,
    output reg tbl_ready,
    // Entry hand-off to the read mover
    output reg rd_entry_valid,
    output reg [159:0] read_table_entry_bus,
    input wire rd_entry_ready,
    input wire rd_done,
    // Entry hand-off to the write mover
    output reg wr_entry_valid,
    output reg [159:0] write_table_entry_bus,
    input wire wr_entry_ready,
    input wire wr_done,
    // Single-dword TX slave path (status and MSI)
    output wire txs_valid,
    output wire [63:0] txs_addr,
    output wire [31:0] txs_data,
    input wire txs_ready,
    output reg busy
);
    localparam DEPTH = 1 << FIFO_AW;
    localparam CW = FIFO_AW + 1;
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_FETCH = 7'h02;
    localparam [6:0] S_POP = 7'h04;
    localparam [6:0] S_DISP = 7'h08;
    localparam [6:0] S_WAIT = 7'h10;
    localparam [6:0] S_STAT = 7'h20;
    localparam [6:0] S_MSI = 7'h40;

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    reg [63:0] tbl_base_q;
    reg [63:0] sts_base_q;
    reg [63:0] msi_addr_q;
    reg [31:0] msi_data_q;
    reg msi_en_q;
    reg [6:0] state_q;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] recv_q;
    reg [CW-1:0] left_q;
    reg [63:0] fetch_addr_q;
    reg [31:0] fetch_left_q;
    reg [159:0] cur_q;
    reg [159:0] fifo_mem [0:DEPTH-1];
    reg [FIFO_AW-1:0] wr_ptr_q;
    reg [FIFO_AW-1:0] rd_ptr_q;

    wire [12:0] chunk;
    wire [CW-1:0] cnt_req;
    wire start;
    wire tbl_take;
    reg sk_valid;
    reg [95:0] sk_data;
    wire sk_ready;
    wire [7:0] cur_id;

    assign cur_id = cur_q[`PDM_F_ID_MSB:`PDM_F_ID_LSB];
    assign tbl_take = tbl_valid & tbl_ready;
    // Table size is clamped to FIFO depth: the whole table must fit
    // locally before dispatch starts, so larger tables are truncated.
    assign cnt_req = (host_register_master_wdata > DEPTH) ?
        DEPTH[CW-1:0] : host_register_master_wdata[CW-1:0];
    assign start = host_register_master_write && (state_q == S_IDLE) &&
        (host_register_master_addr == `PDM_REG_TBL_CNT) &&
        (host_register_master_wdata != 32'h0000_0000);

    // ----------------------------------------------------------------
    // Request splitter and TX buffer
    // ----------------------------------------------------------------
    pdm_split #(
        .MAX_BYTES(MAX_RD_BYTES)
    ) u_split (
        .page_offs(fetch_addr_q[11:0]),
        .remain(fetch_left_q),
        .chunk(chunk)
    );

    pdm_skid #(
        .W(96)
    ) u_skid (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .in_valid(sk_valid),
        .in_data(sk_data),
        .in_ready(sk_ready),
        .out_valid(txs_valid),
        .out_data({txs_addr, txs_data}),
        .out_ready(txs_ready)
    );

    always @* begin
        sk_valid = `PDM_ZERO;
        sk_data = {96{`PDM_ZERO}};
        if (state_q == S_STAT) begin
            sk_valid = `PDM_ONE;
            sk_data = {sts_base_q + {54'h0, cur_id, 2'b00},
                `PDM_ONE, 23'h000000, cur_id};
        end else if (state_q == S_MSI) begin
            sk_valid = `PDM_ONE;
            sk_data = {msi_addr_q, msi_data_q};
        end
    end

    // ----------------------------------------------------------------
    // Host register writes
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            tbl_base_q <= {64{`PDM_ZERO}};
            sts_base_q <= {64{`PDM_ZERO}};
            msi_addr_q <= {64{`PDM_ZERO}};
            msi_data_q <= {32{`PDM_ZERO}};
            msi_en_q <= `PDM_ZERO;
        end else if (ce && host_register_master_write) begin
            case (host_register_master_addr)
                `PDM_REG_TBL_LO: tbl_base_q[31:0] <= host_register_master_wdata;
                `PDM_REG_TBL_HI: tbl_base_q[63:32] <= host_register_master_wdata;
                `PDM_REG_STS_LO: sts_base_q[31:0] <= host_register_master_wdata;
                `PDM_REG_STS_HI: sts_base_q[63:32] <= host_register_master_wdata;
                `PDM_REG_MSI_LO: msi_addr_q[31:0] <= host_register_master_wdata;
                `PDM_REG_MSI_HI: msi_addr_q[63:32] <= host_register_master_wdata;
                `PDM_REG_MSI_DATA: msi_data_q <= host_register_master_wdata;
                `PDM_REG_CTRL:
                    msi_en_q <= host_register_master_wdata[`PDM_CTRL_MSI_EN];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Local table FIFO
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (ce && tbl_take) begin
            fifo_mem[wr_ptr_q] <= tbl_data;
        end
    end

    // ----------------------------------------------------------------
    // Control sequence
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state_q <= S_IDLE;
            cnt_q <= {CW{`PDM_ZERO}};
            recv_q <= {CW{`PDM_ZERO}};
            left_q <= {CW{`PDM_ZERO}};
            fetch_addr_q <= {64{`PDM_ZERO}};
            fetch_left_q <= {32{`PDM_ZERO}};
            cur_q <= {160{`PDM_ZERO}};
            wr_ptr_q <= {FIFO_AW{`PDM_ZERO}};
            rd_ptr_q <= {FIFO_AW{`PDM_ZERO}};
            rdreq_valid <= `PDM_ZERO;
            rdreq_addr <= {64{`PDM_ZERO}};
            rdreq_bytes <= {13{`PDM_ZERO}};
            tbl_ready <= `PDM_ZERO;
            rd_entry_valid <= `PDM_ZERO;
            read_table_entry_bus <= {160{`PDM_ZERO}};
            wr_entry_valid <= `PDM_ZERO;
            write_table_entry_bus <= {160{`PDM_ZERO}};
            busy <= `PDM_ZERO;
        end else if (ce) begin
            busy <= (state_q != S_IDLE) || start;
            if (tbl_take) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
                recv_q <= recv_q + 1'b1;
                if (recv_q + 1'b1 == cnt_q) begin
                    tbl_ready <= `PDM_ZERO;
                end
            end
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        cnt_q <= cnt_req;
                        left_q <= cnt_req;
                        recv_q <= {CW{`PDM_ZERO}};
                        fetch_addr_q <= tbl_base_q;
                        fetch_left_q <= `PDM_ENTRY_BYTES *
                            {{(32-CW){`PDM_ZERO}}, cnt_req};
                        tbl_ready <= `PDM_ONE;
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    // Requests never span a page and are paced by the
                    // mover's ready, which carries its tag and credit limits.
                    if ((fetch_left_q != 32'h0000_0000) &&
                        (!rdreq_valid || rdreq_ready)) begin
                        rdreq_valid <= `PDM_ONE;
                        rdreq_addr <= fetch_addr_q;
                        rdreq_bytes <= chunk;
                        fetch_addr_q <= fetch_addr_q + {51'h0, chunk};
                        fetch_left_q <= fetch_left_q - {19'h0, chunk};
                    end else if (rdreq_ready) begin
                        rdreq_valid <= `PDM_ZERO;
                    end
                    if ((recv_q == cnt_q) && !rdreq_valid &&
                        (fetch_left_q == 32'h0000_0000)) begin
                        state_q <= S_POP;
                    end
                end
                S_POP: begin
                    cur_q <= fifo_mem[rd_ptr_q];
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                    left_q <= left_q - 1'b1;
                    state_q <= S_DISP;
                end
                S_DISP: begin
                    if (cur_q[`PDM_F_DIR]) begin
                        wr_entry_valid <= `PDM_ONE;
                        write_table_entry_bus <= cur_q;
                    end else begin
                        rd_entry_valid <= `PDM_ONE;
                        read_table_entry_bus <= cur_q;
                    end
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (rd_entry_valid && rd_entry_ready) begin
                        rd_entry_valid <= `PDM_ZERO;
                    end
                    if (wr_entry_valid && wr_entry_ready) begin
                        wr_entry_valid <= `PDM_ZERO;
                    end
                    if (!rd_entry_valid && !wr_entry_valid &&
                        (cur_q[`PDM_F_DIR] ? wr_done : rd_done)) begin
                        state_q <= S_STAT;
                    end
                end
                S_STAT: begin
                    if (sk_ready) begin
                        if (left_q != {CW{`PDM_ZERO}}) begin
                            state_q <= S_POP;
                        end else if (msi_en_q) begin
                            state_q <= S_MSI;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_MSI: begin
                    if (sk_ready) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // pdm_desc_ctrl
`default_nettype wire

/* pdm_top_note_placeholder_unused.v */
// Empty compile unit kept for the folder; holds no module
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* pdm_desc_ctrl_properties.sv */
// Port assertions for the descriptor controller, bound to its top
`timescale 1ns/10ps
`default_nettype none
module pdm_desc_ctrl_properties #(
    parameter int MAX_RD_BYTES = 512
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic host_register_master_write,
    input wire logic [3:0] host_register_master_addr,
    input wire logic [31:0] host_register_master_wdata,
    input wire logic rdreq_valid,
    input wire logic [63:0] rdreq_addr,
    input wire logic [12:0] rdreq_bytes,
    input wire logic rdreq_ready,
    input wire logic rd_entry_valid,
    input wire logic [159:0] read_table_entry_bus,
    input wire logic rd_entry_ready,
    input wire logic rd_done,
    input wire logic wr_entry_valid,
    input wire logic [159:0] write_table_entry_bus,
    input wire logic wr_entry_ready,
    input wire logic wr_done,
    input wire logic txs_valid,
    input wire logic txs_ready,
    input wire logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // High while a mover holds an entry and has not reported done
    logic out_q;
    always_ff @(posedge clk) begin
        if (srst)
            out_q <= 1'b0;
        else if ((rd_entry_valid && rd_entry_ready) ||
                 (wr_entry_valid && wr_entry_ready))
            out_q <= 1'b1;
        else if (rd_done || wr_done)
            out_q <= 1'b0;
    end
    sequence start_s;
        host_register_master_write && host_register_master_addr == 4'h2 &&
            host_register_master_wdata != 32'h0 && !busy;
    endsequence
    sequence fetch_s;
        busy ##1 rdreq_valid;
    endsequence
    start_fetch_a: assert property (start_s |=> fetch_s)
        else $error("table fetch did not follow start");
    page_cross_a: assert property (rdreq_valid |->
        {2'b0, rdreq_addr[11:0]} + {1'b0, rdreq_bytes} <= 14'h1000)
        else $error("fetch crosses a 4 KB page");
    chunk_size_a: assert property (rdreq_valid |-> rdreq_bytes != 13'h0 &&
        rdreq_bytes <= MAX_RD_BYTES) else $error("fetch size out of range");
    fetch_hold_a: assert property (rdreq_valid && !rdreq_ready |=>
        rdreq_valid && $stable(rdreq_bytes)) else $error("fetch dropped");
    rd_hold_a: assert property (rd_entry_valid && !rd_entry_ready |=>
        rd_entry_valid && $stable(read_table_entry_bus))
        else $error("read entry dropped");
    wr_hold_a: assert property (wr_entry_valid && !wr_entry_ready |=>
        wr_entry_valid && $stable(write_table_entry_bus))
        else $error("write entry dropped");
    one_mover_a: assert property (!(rd_entry_valid && wr_entry_valid) &&
        (!rd_entry_valid || !read_table_entry_bus[159]) &&
        (!wr_entry_valid || write_table_entry_bus[159]))
        else $error("entry sent to wrong mover");
    txs_hold_a: assert property (txs_valid && !txs_ready |=> txs_valid)
        else $error("tx word dropped");
    status_after_done_a: assert property ($rose(txs_valid) |-> !out_q)
        else $error("status before mover done");
endmodule // pdm_desc_ctrl_properties

bind pdm_desc_ctrl pdm_desc_ctrl_properties #(.MAX_RD_BYTES(MAX_RD_BYTES))
    i_pdm_desc_ctrl_properties (.clk(clk), .srst(srst),
    .host_register_master_write(host_register_master_write),
    .host_register_master_addr(host_register_master_addr),
    .host_register_master_wdata(host_register_master_wdata),
    .rdreq_valid(rdreq_valid), .rdreq_addr(rdreq_addr),
    .rdreq_bytes(rdreq_bytes), .rdreq_ready(rdreq_ready),
    .rd_entry_valid(rd_entry_valid), .rd_entry_ready(rd_entry_ready),
    .read_table_entry_bus(read_table_entry_bus), .rd_done(rd_done),
    .wr_entry_valid(wr_entry_valid), .wr_entry_ready(wr_entry_ready),
    .write_table_entry_bus(write_table_entry_bus), .wr_done(wr_done),
    .txs_valid(txs_valid), .txs_ready(txs_ready), .busy(busy));
`default_nettype wire

/* pdm_mover_model.sv */
// Far side model: table return, both movers and the TX slave
`timescale 1ns/10ps
`default_nettype none
module pdm_mover_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] stall,
    input wire logic rdreq_valid,
    input wire logic [12:0] rdreq_bytes,
    output logic rdreq_ready,
    output logic tbl_valid,
    output logic [159:0] tbl_data,
    input wire logic tbl_ready,
    input wire logic rd_entry_valid,
    output logic rd_entry_ready,
    output logic rd_done,
    input wire logic wr_entry_valid,
    output logic wr_entry_ready,
    output logic wr_done,
    output logic txs_ready
);
    logic [15:0] got_q;
    logic [7:0] idx_q;
    logic [2:0] cnt_q;
    logic dir_q;
    logic [159:0] ent;
    // Entry k: direction k[1], id k+0x40, k in the low byte
    assign ent = {idx_q[1], 5'h0, idx_q + 8'h40, 138'h0, idx_q};
    // Released data shows garbage so a stale entry cannot pass
    assign tbl_data = tbl_valid ? ent : ~ent;
    assign rdreq_ready = !stall[0];
    assign rd_entry_ready = !stall[2];
    assign wr_entry_ready = !stall[2];
    assign txs_ready = !stall[3];
    always @(posedge clk) begin
        if (srst) begin
            got_q <= 16'h0;
            idx_q <= 8'h0;
            tbl_valid <= 1'b0;
            cnt_q <= 3'h0;
            dir_q <= 1'b0;
            rd_done <= 1'b0;
            wr_done <= 1'b0;
        end else begin
            if (rdreq_valid && rdreq_ready)
                got_q <= got_q + {3'h0, rdreq_bytes};
            if (tbl_valid && tbl_ready) begin
                tbl_valid <= 1'b0;
                idx_q <= idx_q + 8'h1;
            end else if (!stall[1] && got_q >= 16'd20 * ({8'h0, idx_q} + 16'd1))
                tbl_valid <= 1'b1;
            if ((rd_entry_valid && rd_entry_ready) ||
                (wr_entry_valid && wr_entry_ready)) begin
                cnt_q <= {1'b1, stall[1:0]};
                dir_q <= wr_entry_valid;
            end else if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
            rd_done <= cnt_q == 3'h1 && !dir_q;
            wr_done <= cnt_q == 3'h1 && dir_q;
        end
    end
endmodule // pdm_mover_model
`default_nettype wire

/* pcie_descriptor_dma_movers_test.sv */
// Self-checking bench: descriptor controller against the mover model
`timescale 1ns/10ps
`default_nettype none
module pcie_descriptor_dma_movers_test;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, hw = 1'b0, slow = 1'b0;
    logic [3:0] ha = 4'h0, stall = 4'h0;
    logic [31:0] hd = 32'h0;
    logic rdreq_valid, rdreq_ready, tbl_valid, tbl_ready, busy;
    logic rd_entry_valid, rd_entry_ready, rd_done, txs_valid, txs_ready;
    logic wr_entry_valid, wr_entry_ready, wr_done;
    logic [63:0] rdreq_addr, txs_addr, fa, b21;
    logic [12:0] rdreq_bytes;
    logic [31:0] txs_data;
    logic [159:0] tbl_data, rd_bus, wr_bus;
    logic [160:0] eq[$], tq[$];
    localparam logic [63:0] STS = 64'h0000_0001_0000_8000;
    integer seed = 65548, errors = 0, tests_run = 0, nent = 0;
    pdm_desc_ctrl #(.MAX_RD_BYTES(64)) i_pdm_desc_ctrl (.clk(clk),
        .srst(srst), .ce(ce), .host_register_master_write(hw),
        .host_register_master_addr(ha), .host_register_master_wdata(hd),
        .rdreq_valid(rdreq_valid), .rdreq_addr(rdreq_addr),
        .rdreq_bytes(rdreq_bytes), .rdreq_ready(rdreq_ready),
        .tbl_valid(tbl_valid), .tbl_data(tbl_data), .tbl_ready(tbl_ready),
        .rd_entry_valid(rd_entry_valid), .read_table_entry_bus(rd_bus),
        .rd_entry_ready(rd_entry_ready), .rd_done(rd_done),
        .wr_entry_valid(wr_entry_valid), .write_table_entry_bus(wr_bus),
        .wr_entry_ready(wr_entry_ready), .wr_done(wr_done),
        .txs_valid(txs_valid), .txs_addr(txs_addr), .txs_data(txs_data),
        .txs_ready(txs_ready), .busy(busy));
    pdm_mover_model i_pdm_mover_model (.clk(clk), .srst(srst), .stall(stall),
        .rdreq_valid(rdreq_valid), .rdreq_bytes(rdreq_bytes),
        .rdreq_ready(rdreq_ready), .tbl_valid(tbl_valid),
        .tbl_data(tbl_data), .tbl_ready(tbl_ready),
        .rd_entry_valid(rd_entry_valid), .rd_entry_ready(rd_entry_ready),
        .rd_done(rd_done), .wr_entry_valid(wr_entry_valid),
        .wr_entry_ready(wr_entry_ready), .wr_done(wr_done),
        .txs_ready(txs_ready));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) stall <= #1 slow ? 4'($random(seed)) : 4'h0;
    task automatic check(input string what, input logic [160:0] seen,
                         input logic [160:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Oldest note is compared whenever a result leaves the controller
    task automatic take(input logic w, input logic [160:0] v);
        if ((w ? tq.size() : eq.size()) == 0)
            check("unexpected transfer", v, 161'h0);
        else
            check(w ? "tx word" : "entry", v, w ? tq.pop_front() : eq.pop_front());
    endtask
    always @(posedge clk) begin
        if (!srst) begin
            if (rdreq_valid && rdreq_ready) begin
                check("fetch address", {97'h0, rdreq_addr}, {97'h0, fa});
                fa = fa + {51'h0, rdreq_bytes};
            end
            if (rd_entry_valid && rd_entry_ready)
                take(1'b0, {1'b0, rd_bus});
            if (wr_entry_valid && wr_entry_ready)
                take(1'b0, {1'b1, wr_bus});
            if (txs_valid && txs_ready)
                take(1'b1, {65'h0, txs_addr, txs_data});
        end
    end
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        hw = 1'b1;
        ha = a;
        hd = d;
        @(posedge clk);
        #1;
        hw = 1'b0;
    endtask
    task automatic run_table(input logic [31:0] n, input logic [63:0] base,
                             input logic msi, input logic again);
        integer k, m, i;
        logic [7:0] g;
        logic [31:0] md;
        md = $random(seed);
        m = (n > 16) ? 16 : n;
        fa = base;
        wr_reg(4'h0, base[31:0]);
        wr_reg(4'h1, base[63:32]);
        wr_reg(4'h3, STS[31:0]);
        wr_reg(4'h4, STS[63:32]);
        wr_reg(4'h5, 32'hfee0_0000);
        wr_reg(4'h6, 32'h0);
        wr_reg(4'h7, md);
        wr_reg(4'h8, {31'h0, msi});
        wr_reg(4'hf, 32'hffff_ffff);
        for (k = 0; k < m; k++) begin
            g = nent[7:0] + k[7:0];
            eq.push_back({g[1], g[1], 5'h0, g + 8'h40, 138'h0, g});
            tq.push_back({65'h0, STS + {54'h0, g + 8'h40, 2'b0}, 24'h80_0000,
                          g + 8'h40});
        end
        if (msi && m > 0)
            tq.push_back({65'h0, 64'h0000_0000_fee0_0000, md});
        nent = nent + m;
        wr_reg(4'h2, n);
        if (again)
            wr_reg(4'h2, 32'h3);
        for (i = 0; i < 4000 && (busy !== 1'b0 || eq.size() + tq.size() > 0); i++)
            @(posedge clk);
        if (i == 4000) begin
            errors = errors + 1;
            give_verdict();
        end
        check("fetched end", {97'h0, fa}, {97'h0, base + 64'(20 * m)});
        $display("test table of %0d entries done", n);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        run_table(32'd1, 64'h0000_0002_0000_0100, 1'b0, 1'b0);
        slow = 1'b1;
        run_table(32'd6, 64'h0000_0000_1234_0fd8, 1'b1, 1'b0);
        run_table(32'd0, 64'h0000_0000_0000_2000, 1'b1, 1'b0);
        b21 = {32'h0, 20'h5a5a5, 4'($random(seed)), 8'hf0};
        run_table(32'd21, b21, 1'b1, 1'b1);
        // Restart reuses the programmed base; cut before any entry leaves
        fa = b21;
        wr_reg(4'h2, 32'h8);
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b1;
        eq.delete();
        tq.delete();
        nent = 0;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
        check("idle after reset", {158'h0, busy, rdreq_valid, txs_valid}, 161'h0);
        $display("test reset in mid-run done");
        run_table(32'd4, 64'h0000_0000_0000_0ffc, 1'b1, 1'b0);
        give_verdict();
    end
endmodule // pcie_descriptor_dma_movers_test
`default_nettype wire
